// ### sfrb_cfg.svh
`ifndef SFRB_CFG_SVH
`define SFRB_CFG_SVH

// Register offsets within a bank
`define SFRB_IDX_INDIRECT    7'h00
`define SFRB_IDX_TIMER0      7'h01
`define SFRB_IDX_PCL         7'h02
`define SFRB_IDX_STATUS      7'h03
`define SFRB_IDX_POINTER     7'h04
`define SFRB_IDX_PORT_A      7'h05
`define SFRB_IDX_PORT_B      7'h06
`define SFRB_IDX_PORT_C      7'h07
`define SFRB_IDX_PORT_D      7'h08
`define SFRB_IDX_PORT_E      7'h09
`define SFRB_IDX_HOLDING     7'h0a
`define SFRB_IDX_INTERRUPT_CONTROL      7'h0b
`define SFRB_IDX_FLAGS_ONE   7'h0c
`define SFRB_IDX_FLAGS_TWO   7'h0d
`define SFRB_IDX_T1_LOW      7'h0e
`define SFRB_IDX_T1_HIGH     7'h0f
`define SFRB_IDX_T1_CTRL     7'h10
`define SFRB_IDX_T2_CTRL     7'h12
`define SFRB_IDX_SERIAL_BUF  7'h13
`define SFRB_IDX_CCP1_LOW    7'h15
`define SFRB_IDX_CCP1_HIGH   7'h16
`define SFRB_IDX_CCP1_CTRL   7'h17
`define SFRB_IDX_RX_STATUS   7'h18
`define SFRB_IDX_RX_DATA     7'h1a
`define SFRB_IDX_CCP2_LOW    7'h1b
`define SFRB_IDX_CCP2_HIGH   7'h1c
`define SFRB_IDX_CCP2_CTRL   7'h1d
`define SFRB_IDX_CONV_RESULT 7'h1e
`define SFRB_IDX_CONV_CTRL   7'h1f
`define SFRB_IDX_RESET_CAUSE 7'h0e
`define SFRB_SFR_LIMIT       7'h20
`define SFRB_RAM_WORDS       96
`define SFRB_BANK_ZERO       2'h0
`define SFRB_BANK_ONE        2'h1

// Implemented-bit masks
`define SFRB_MASK_FULL       8'hff
`define SFRB_MASK_NONE       8'h00
`define SFRB_MASK_PORT_A     8'h3f
`define SFRB_MASK_PORT_E     8'h07
`define SFRB_MASK_HOLDING    8'h1f
`define SFRB_MASK_FLAGS_TWO  8'h01
`define SFRB_MASK_CTRL_SIX   8'h3f
`define SFRB_MASK_T2_CTRL    8'h7f
`define SFRB_MASK_RX_STATUS  8'hf7
`define SFRB_MASK_CONV_CTRL  8'hfd

// Reset values and bits kept over a non-power-up reset
`define SFRB_RESET_ZERO      8'h00
`define SFRB_STATUS_POR      8'h18
`define SFRB_STATUS_HW_MASK  8'h18
`define SFRB_STATUS_KEEP     8'h07
`define SFRB_PORT_A_KEEP     8'h10
`define SFRB_LOW_BIT_KEEP    8'h01

// Bit positions
`define SFRB_BIT_IND_BANK    7
`define SFRB_BIT_TIMEOUT     4
`define SFRB_BIT_POWERDOWN   3
`define SFRB_BIT_CAUSE_POWER 1
`define SFRB_BIT_CAUSE_BROWN 0

`endif

// ### sfrb_pkg.sv
package sfrb_pkg;

  typedef struct packed {
    logic       is_sfr;
    logic       is_ram;
    logic       is_cause;
    logic [4:0] sfr_idx;
    logic [6:0] ram_idx;
  } sfrb_target_type;

  typedef struct packed {
    logic [5:0] port_a;
    logic [7:0] port_b;
    logic [7:0] port_c;
    logic [7:0] port_d;
    logic [2:0] port_e;
  } sfrb_pins_type;

  typedef struct packed {
    logic watchdog;
    logic sleeping;
  } sfrb_cause_type;

  typedef enum logic [1:0] {
    SFRB_IDLE   = 2'b01,
    SFRB_ANSWER = 2'b10
  } sfrb_apb_state_type;

endpackage

// ### sfrb_bank0.sv
`timescale 1ns/1ps
`include "sfrb_cfg.svh"

module sfrb_bank0 #(
  parameter bit HAS_PORT_DE  = 1'b1,
  parameter bit HAS_BROWNOUT = 1'b1
) (
  // Clock and power-on reset
  input  wire logic                     sys_clk_in,
  input  wire logic                     resetn_in,
  // Other resets
  input  wire logic                     other_reset_in,
  input  wire sfrb_pkg::sfrb_cause_type other_cause_in,
  // APB slave
  input  wire logic                     psel_in,
  input  wire logic                     penable_in,
  input  wire logic                     pwrite_in,
  input  wire logic [11:0]              paddr_in,
  input  wire logic [31:0]              pwdata_in,
  output logic      [31:0]              prdata_out,
  output logic                          pready_out,
  // Peripheral and pin side
  input  wire sfrb_pkg::sfrb_pins_type  pins_in,
  input  wire logic [7:0]               rx_data_in,
  input  wire logic [7:0]               conv_result_in,
  input  wire logic [7:0]               flag_one_set_in,
  input  wire logic                     flag_two_set_in,
  input  wire logic                     pc_step_in,
  output logic      [12:0]              pc_out,
  output logic      [31:0][7:0]         sfr_image_out
);

  logic [31:0][7:0]                sfr_q;
  logic [31:0][7:0]                sfr_d;
  logic [31:0][7:0]                view;
  logic [7:0]                      ram_q [`SFRB_RAM_WORDS];
  logic [12:0]                     pc_q;
  logic [12:0]                     pc_d;
  logic [1:0]                      cause_q;
  logic [1:0]                      cause_d;
  logic [31:0]                     prdata_q;
  logic [31:0]                     prdata_d;
  sfrb_pkg::sfrb_apb_state_type    state_q;
  sfrb_pkg::sfrb_apb_state_type    state_d;

  function automatic logic is_core(input logic [6:0] off);
    is_core = off inside {`SFRB_IDX_INDIRECT, `SFRB_IDX_PCL, `SFRB_IDX_STATUS,
                          `SFRB_IDX_POINTER, `SFRB_IDX_HOLDING, `SFRB_IDX_INTERRUPT_CONTROL};
  endfunction

  function automatic sfrb_pkg::sfrb_target_type decode_addr(input logic [8:0] addr);
    sfrb_pkg::sfrb_target_type t;
    logic [6:0]                off;
    logic [1:0]                bank;
    t    = '0;
    off  = addr[6:0];
    bank = addr[8:7];
    if (off < `SFRB_SFR_LIMIT && (bank == `SFRB_BANK_ZERO || is_core(off))) begin
      t.is_sfr  = 1'b1;
      t.sfr_idx = off[4:0];
    end else if (bank == `SFRB_BANK_ZERO) begin
      t.is_ram  = 1'b1;
      t.ram_idx = off - `SFRB_SFR_LIMIT;
    end else if (bank == `SFRB_BANK_ONE && off == `SFRB_IDX_RESET_CAUSE) begin
      t.is_cause = 1'b1;
    end
    return t;
  endfunction

  function automatic logic [7:0] impl_mask(input logic [6:0] off);
    case (off)
      `SFRB_IDX_INDIRECT:   impl_mask = `SFRB_MASK_NONE;
      `SFRB_IDX_PORT_A:     impl_mask = `SFRB_MASK_PORT_A;
      `SFRB_IDX_PORT_D:     impl_mask = HAS_PORT_DE ? `SFRB_MASK_FULL : `SFRB_MASK_NONE;
      `SFRB_IDX_PORT_E:     impl_mask = HAS_PORT_DE ? `SFRB_MASK_PORT_E : `SFRB_MASK_NONE;
      `SFRB_IDX_HOLDING:    impl_mask = `SFRB_MASK_HOLDING;
      `SFRB_IDX_FLAGS_TWO:  impl_mask = `SFRB_MASK_FLAGS_TWO;
      `SFRB_IDX_T1_CTRL:    impl_mask = `SFRB_MASK_CTRL_SIX;
      `SFRB_IDX_T2_CTRL:    impl_mask = `SFRB_MASK_T2_CTRL;
      `SFRB_IDX_CCP1_CTRL:  impl_mask = `SFRB_MASK_CTRL_SIX;
      `SFRB_IDX_RX_STATUS:  impl_mask = `SFRB_MASK_RX_STATUS;
      `SFRB_IDX_CCP2_CTRL:  impl_mask = `SFRB_MASK_CTRL_SIX;
      `SFRB_IDX_CONV_CTRL:  impl_mask = `SFRB_MASK_CONV_CTRL;
      default:              impl_mask = `SFRB_MASK_FULL;
    endcase
  endfunction

  // Counter low byte and read-only inputs are not written through the generic path
  function automatic logic [7:0] write_mask(input logic [6:0] off);
    case (off)
      `SFRB_IDX_PCL,
      `SFRB_IDX_RX_DATA,
      `SFRB_IDX_CONV_RESULT: write_mask = `SFRB_MASK_NONE;
      `SFRB_IDX_STATUS:      write_mask = ~`SFRB_STATUS_HW_MASK;
      default:               write_mask = `SFRB_MASK_FULL;
    endcase
  endfunction

  function automatic logic [7:0] keep_mask(input logic [6:0] off);
    case (off)
      `SFRB_IDX_TIMER0, `SFRB_IDX_POINTER, `SFRB_IDX_PORT_B, `SFRB_IDX_PORT_C,
      `SFRB_IDX_PORT_D, `SFRB_IDX_PORT_E, `SFRB_IDX_T1_LOW, `SFRB_IDX_T1_HIGH,
      `SFRB_IDX_T1_CTRL, `SFRB_IDX_SERIAL_BUF, `SFRB_IDX_CCP1_LOW, `SFRB_IDX_CCP1_HIGH,
      `SFRB_IDX_CCP2_LOW, `SFRB_IDX_CCP2_HIGH, `SFRB_IDX_CONV_RESULT:
                             keep_mask = `SFRB_MASK_FULL;
      `SFRB_IDX_STATUS:      keep_mask = `SFRB_STATUS_KEEP;
      `SFRB_IDX_PORT_A:      keep_mask = `SFRB_PORT_A_KEEP;
      `SFRB_IDX_INTERRUPT_CONTROL,
      `SFRB_IDX_RX_STATUS:   keep_mask = `SFRB_LOW_BIT_KEEP;
      default:               keep_mask = `SFRB_MASK_NONE;
    endcase
  endfunction

  // Address decode
  wire                            access     = psel_in && penable_in;
  wire                            addr_ok    = (paddr_in[1:0] == 2'h0) && !paddr_in[11];
  wire [7:0]                      status_val = sfr_q[`SFRB_IDX_STATUS];
  wire [7:0]                      ptr_val    = sfr_q[`SFRB_IDX_POINTER];
  wire [4:0]                      holding    = sfr_q[`SFRB_IDX_HOLDING][4:0];
  wire [7:0]                      flags_val  = sfr_q[`SFRB_IDX_FLAGS_ONE];
  wire [7:0]                      wr_byte    = pwdata_in[7:0];
  wire sfrb_pkg::sfrb_target_type apb_tgt    = decode_addr(paddr_in[10:2]);
  // Bank bit of the pointer path is trusted to be clear on small parts
  wire sfrb_pkg::sfrb_target_type ind_raw    = decode_addr({status_val[`SFRB_BIT_IND_BANK], ptr_val});
  wire                            ind_self   = ind_raw.is_sfr && (ind_raw.sfr_idx == `SFRB_IDX_INDIRECT);
  wire                            via_ptr    = apb_tgt.is_sfr && (apb_tgt.sfr_idx == `SFRB_IDX_INDIRECT);
  // Pointing the pointer at the indirect port itself reaches nothing
  wire sfrb_pkg::sfrb_target_type ind_tgt    = ind_self ? '0 : ind_raw;
  wire sfrb_pkg::sfrb_target_type tgt        = !addr_ok ? '0 : (via_ptr ? ind_tgt : apb_tgt);
  wire                            wr_commit  = (state_q == sfrb_pkg::SFRB_ANSWER) && access && pwrite_in;
  wire                            rd_take    = (state_q == sfrb_pkg::SFRB_IDLE) && access && !pwrite_in;
  wire [1:0]                      cause_mask = {1'b1, HAS_BROWNOUT};
  wire [7:0]                      status_cause = ({7'h00, ~other_cause_in.watchdog} << `SFRB_BIT_TIMEOUT) |
                                                 ({7'h00, ~other_cause_in.sleeping} << `SFRB_BIT_POWERDOWN);
  wire [7:0]                      rd_byte    = tgt.is_sfr   ? view[tgt.sfr_idx] :
                                               tgt.is_ram   ? ram_q[tgt.ram_idx] :
                                               tgt.is_cause ? {6'h00, cause_q & cause_mask} :
                                               `SFRB_RESET_ZERO;

  // Register storage and read view
  for (genvar i = 0; i < 32; i++) begin : g_sfr
    localparam logic [6:0] OFF = 7'(i);
    wire       hit     = wr_commit && tgt.is_sfr && (tgt.sfr_idx == OFF[4:0]);
    wire [7:0] wm      = impl_mask(OFF) & write_mask(OFF);
    wire [7:0] por_val = (OFF == `SFRB_IDX_STATUS) ? `SFRB_STATUS_POR : `SFRB_RESET_ZERO;
    wire [7:0] oth_val = (OFF == `SFRB_IDX_STATUS) ? status_cause : `SFRB_RESET_ZERO;
    wire [7:0] hw_set  = (OFF == `SFRB_IDX_FLAGS_ONE) ? flag_one_set_in :
                         (OFF == `SFRB_IDX_FLAGS_TWO) ? {7'h00, flag_two_set_in} : `SFRB_RESET_ZERO;
    wire [7:0] written = hit ? ((sfr_q[i] & ~wm) | (wr_byte & wm)) : sfr_q[i];
    wire [7:0] src     = (OFF == `SFRB_IDX_PCL)         ? pc_q[7:0] :
                         (OFF == `SFRB_IDX_PORT_A)      ? {2'h0, pins_in.port_a} :
                         (OFF == `SFRB_IDX_PORT_B)      ? pins_in.port_b :
                         (OFF == `SFRB_IDX_PORT_C)      ? pins_in.port_c :
                         (OFF == `SFRB_IDX_PORT_D)      ? pins_in.port_d :
                         (OFF == `SFRB_IDX_PORT_E)      ? {5'h00, pins_in.port_e} :
                         (OFF == `SFRB_IDX_RX_DATA)     ? rx_data_in :
                         (OFF == `SFRB_IDX_CONV_RESULT) ? conv_result_in : sfr_q[i];
    // Hardware flag set is ORed after the write so a set in the clearing cycle wins
    assign sfr_d[i] = !resetn_in      ? por_val :
                      other_reset_in  ? ((sfr_q[i] & keep_mask(OFF)) | oth_val) :
                      (written | (hw_set & impl_mask(OFF)));
    assign view[i]  = src & impl_mask(OFF);
  end

  // Program counter: loading the low byte pulls in the holding bits
  wire pcl_wr = wr_commit && tgt.is_sfr && (tgt.sfr_idx == `SFRB_IDX_PCL);
  assign pc_d = (!resetn_in || other_reset_in) ? 13'h0000 :
                pcl_wr     ? {holding, wr_byte} :
                pc_step_in ? pc_q + 13'h0001 : pc_q;

  // Reset cause bits: cleared by power-up, kept by other resets
  assign cause_d = !resetn_in ? 2'h0 :
                   (wr_commit && tgt.is_cause) ? (wr_byte[1:0] & cause_mask) :
                   cause_q;

  // APB answer: one wait state, read data sampled in the first access cycle
  always_comb begin
    case (state_q)
      sfrb_pkg::SFRB_IDLE:   state_d = access ? sfrb_pkg::SFRB_ANSWER : sfrb_pkg::SFRB_IDLE;
      sfrb_pkg::SFRB_ANSWER: state_d = sfrb_pkg::SFRB_IDLE;
      default:               state_d = sfrb_pkg::SFRB_IDLE;
    endcase
  end
  assign prdata_d = !resetn_in ? 32'h0000_0000 : rd_take ? {24'h00_0000, rd_byte} : prdata_q;

  always_ff @(posedge sys_clk_in) begin
    sfr_q    <= sfr_d;
    pc_q     <= pc_d;
    cause_q  <= cause_d;
    prdata_q <= prdata_d;
    state_q  <= resetn_in ? state_d : sfrb_pkg::SFRB_IDLE;
  end

  // General-purpose memory holds no reset; it is data, not control
  always_ff @(posedge sys_clk_in) begin
    if (wr_commit && tgt.is_ram) begin
      ram_q[tgt.ram_idx] <= wr_byte;
    end
  end

  assign prdata_out    = prdata_q;
  assign pready_out    = state_q[1];
  assign pc_out        = pc_q;
  assign sfr_image_out = sfr_q;

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!resetn_in);

  sequence s_access_start;
    (state_q == sfrb_pkg::SFRB_IDLE) && psel_in && penable_in;
  endsequence

  sequence s_answer;
    pready_out ##1 !pready_out;
  endsequence

  sequence s_read_start;
    s_access_start and !pwrite_in;
  endsequence

  ready_wait_a:
    assert property (s_access_start |=> s_answer)
    else $error("access answer timing wrong");

  unmapped_zero_a:
    assert property (s_read_start and (!tgt.is_sfr && !tgt.is_ram && !tgt.is_cause) |=> prdata_out == 32'h0000_0000)
    else $error("unmapped read not zero");

  pcl_load_a:
    assert property (pcl_wr && !other_reset_in |=> pc_out == {$past(holding), $past(wr_byte)})
    else $error("counter load missed holding bits");

  por_status_a:
    assert property ($rose(resetn_in) |-> status_val == `SFRB_STATUS_POR && pc_out == 13'h0000)
    else $error("power-on values wrong");

  keep_other_a:
    assert property (other_reset_in |=> ptr_val == $past(ptr_val) && cause_q == $past(cause_q))
    else $error("other reset lost kept bits");

  mirror_read_a:
    assert property (s_read_start and (paddr_in == 12'h210) |=> prdata_out[7:0] == $past(ptr_val))
    else $error("core register not mirrored");

  port_de_zero_a:
    assert property (!HAS_PORT_DE |-> view[`SFRB_IDX_PORT_D] == 8'h00 && view[`SFRB_IDX_PORT_E] == 8'h00)
    else $error("absent port reads nonzero");

  brownout_zero_a:
    assert property (!HAS_BROWNOUT |-> !cause_q[`SFRB_BIT_CAUSE_BROWN])
    else $error("absent brown-out bit set");

  indirect_read_a:
    assert property (s_read_start and (paddr_in == 12'h000) && (ptr_val == 8'h03) &&
                     !status_val[`SFRB_BIT_IND_BANK] |=> prdata_out[7:0] == $past(status_val))
    else $error("indirect read wrong target");

  flag_set_a:
    assert property (flag_one_set_in[0] && !other_reset_in |=> flags_val[0])
    else $error("hardware flag set lost");

  sequence s_other_reset;
    other_reset_in;
  endsequence

  sequence s_write_commit;
    wr_commit && !other_reset_in;
  endsequence

  pc_step_a:
    assert property (!pcl_wr && !other_reset_in && pc_step_in |=> pc_out == $past(pc_out) + 13'h0001)
    else $error("counter step wrong");

  pc_hold_a:
    assert property (!pcl_wr && !other_reset_in && !pc_step_in |=> $stable(pc_out))
    else $error("counter moved while idle");

  pc_other_a:
    assert property (s_other_reset |=> pc_out == 13'h0000)
    else $error("counter not cleared by other reset");

  status_other_a:
    assert property (s_other_reset |=>
                     status_val == (($past(status_val) & `SFRB_STATUS_KEEP) | $past(status_cause)))
    else $error("status wrong after other reset");

  holding_other_a:
    assert property (s_other_reset |=> holding == 5'h00)
    else $error("holding not cleared by other reset");

  port_a_data_other_a:
    assert property (s_other_reset |=>
                     sfr_q[`SFRB_IDX_PORT_A] == ($past(sfr_q[`SFRB_IDX_PORT_A]) & `SFRB_PORT_A_KEEP))
    else $error("port A latch wrong after other reset");

  interrupt_control_other_a:
    assert property (s_other_reset |=>
                     sfr_q[`SFRB_IDX_INTERRUPT_CONTROL] == ($past(sfr_q[`SFRB_IDX_INTERRUPT_CONTROL]) & `SFRB_LOW_BIT_KEEP))
    else $error("interrupt control wrong after other reset");

  timer0_other_a:
    assert property (s_other_reset |=> $stable(sfr_q[`SFRB_IDX_TIMER0]))
    else $error("timer zero lost over other reset");

  t2_other_a:
    assert property (s_other_reset |=> sfr_q[`SFRB_IDX_T2_CTRL] == `SFRB_RESET_ZERO)
    else $error("timer two control not cleared");

  por_zero_a:
    assert property ($rose(resetn_in) |-> sfr_q[`SFRB_IDX_TIMER0] == `SFRB_RESET_ZERO &&
                     holding == 5'h00 && cause_q == 2'h0 && !pready_out)
    else $error("power-on clear missed");

  status_hw_a:
    assert property (s_write_commit and (tgt.is_sfr && tgt.sfr_idx == `SFRB_IDX_STATUS) |=>
                     status_val[`SFRB_BIT_TIMEOUT:`SFRB_BIT_POWERDOWN] ==
                     $past(status_val[`SFRB_BIT_TIMEOUT:`SFRB_BIT_POWERDOWN]))
    else $error("status cause bits written");

  rx_read_a:
    assert property (s_read_start and (tgt.is_sfr && tgt.sfr_idx == `SFRB_IDX_RX_DATA) |=>
                     prdata_out[7:0] == $past(rx_data_in))
    else $error("receive data read wrong");

  impl_bits_a:
    assert property (!sfr_q[`SFRB_IDX_T2_CTRL][7] && !sfr_q[`SFRB_IDX_RX_STATUS][3] &&
                     !sfr_q[`SFRB_IDX_CONV_CTRL][1])
    else $error("unimplemented bit stored");

  flags_two_bits_a:
    assert property (sfr_q[`SFRB_IDX_FLAGS_TWO][7:1] == 7'h00)
    else $error("flags two upper bits stored");

  holding_bits_a:
    assert property (sfr_q[`SFRB_IDX_HOLDING][7:5] == 3'h0)
    else $error("holding upper bits stored");

  read_upper_a:
    assert property (prdata_out[31:8] == 24'h00_0000)
    else $error("read data upper bits set");

  write_mirror_a:
    assert property (s_write_commit and (paddr_in == 12'h610) |=> ptr_val == $past(wr_byte))
    else $error("mirrored pointer write lost");

  ind_ram_write_a:
    assert property (s_write_commit and (via_ptr && tgt.is_ram) |=>
                     ram_q[$past(tgt.ram_idx)] == $past(wr_byte))
    else $error("indirect memory write lost");

  self_point_a:
    assert property (s_read_start and (via_ptr && ind_self) |=> prdata_out == 32'h0000_0000)
    else $error("self-pointed indirect read not zero");

  cause_write_a:
    assert property (s_write_commit and tgt.is_cause |=> cause_q == ($past(wr_byte[1:0]) & cause_mask))
    else $error("reset cause write wrong");

  cause_hold_a:
    assert property (!(wr_commit && tgt.is_cause) |=> $stable(cause_q))
    else $error("reset cause changed unwritten");

  flag_two_a:
    assert property (flag_two_set_in && !other_reset_in |=> sfr_q[`SFRB_IDX_FLAGS_TWO][0])
    else $error("flag two set lost");

  rd_hold_a:
    assert property (!rd_take |=> $stable(prdata_out))
    else $error("read data moved without a read");

  pready_idle_a:
    assert property (!psel_in |=> !pready_out)
    else $error("ready without select");

endmodule

// ### sfrb_tb.sv
`timescale 1ns/1ps
module tb;
  logic                     sys_clk_in;
  logic                     resetn_in;
  logic                     other_reset_in;
  sfrb_pkg::sfrb_cause_type other_cause_in;
  logic                     psel;
  logic                     penable;
  logic                     pwrite;
  logic [11:0]              paddr;
  logic [31:0]              pwdata;
  logic [31:0]              prdata;
  logic [31:0]              prdata_lite;
  logic                     pready;
  logic                     pready_lite;
  sfrb_pkg::sfrb_pins_type  pins_in;
  logic [7:0]               rx_data_in;
  logic [7:0]               conv_result_in;
  logic [7:0]               flag_one_set_in;
  logic                     flag_two_set_in;
  logic                     pc_step_in;
  logic [12:0]              pc_out;
  logic [31:0][7:0]         image;
  logic [31:0]              rd;
  logic [31:0]              rd_lite;
  logic [31:0]              seed;
  int                       failures;
  int                       n_compared;

  sfrb_bank0 DUT (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .other_reset_in(other_reset_in),
    .other_cause_in(other_cause_in), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pins_in(pins_in),
    .rx_data_in(rx_data_in), .conv_result_in(conv_result_in), .flag_one_set_in(flag_one_set_in),
    .flag_two_set_in(flag_two_set_in), .pc_step_in(pc_step_in), .pc_out(pc_out), .sfr_image_out(image));

  // Lite variant: no fourth/fifth ports and no brown-out detection
  sfrb_bank0 #(.HAS_PORT_DE(1'b0), .HAS_BROWNOUT(1'b0)) dut_lite (.sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in), .other_reset_in(other_reset_in), .other_cause_in(other_cause_in),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata_lite), .pready_out(pready_lite), .pins_in(pins_in), .rx_data_in(rx_data_in),
    .conv_result_in(conv_result_in), .flag_one_set_in(flag_one_set_in),
    .flag_two_set_in(flag_two_set_in), .pc_step_in(pc_step_in), .pc_out(), .sfr_image_out());

  initial sys_clk_in = 1'b0;
  always #10 sys_clk_in = ~sys_clk_in;

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  function automatic logic [11:0] ad(input int b, input int o);
    return {1'b0, b[1:0], o[6:0], 2'b00};
  endfunction

  function automatic logic [7:0] mask_of(input int o);
    case (o)
      10: return 8'h1f;
      13: return 8'h01;
      16, 23, 29: return 8'h3f;
      18: return 8'h7f;
      24: return 8'hf7;
      31: return 8'hfd;
      1, 3, 4, 11, 12, 14, 15, 17, 19, 20, 21, 22, 25, 27, 28: return 8'hff;
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic [31:0] pin_val(input int o);
    case (o)
      5: return {26'h000_0000, pins_in.port_a};
      6: return {24'h00_0000, pins_in.port_b};
      7: return {24'h00_0000, pins_in.port_c};
      8: return {24'h00_0000, pins_in.port_d};
      default: return {29'h0000_0000, pins_in.port_e};
    endcase
  endfunction

  task automatic end_of_test();
    $display("Compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Ready and read data are taken at the rising edge, before the slave's own update lands
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge sys_clk_in);
    penable <= 1'b1;
    @(posedge sys_clk_in);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge sys_clk_in);
      n++;
    end
    if (pready !== 1'b1) begin
      failures++;
      $display("Error pready expected 1 seen timeout");
      end_of_test();
    end
    rd = prdata;
    rd_lite = prdata_lite;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk_in);
  endtask

  task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 8'h00);
    chk(name, rd, exp);
  endtask

  initial begin
    logic [7:0]  d;
    logic [31:0] exp;
    logic [63:0] wide;
    int          wb;
    failures = 0;
    n_compared = 0;
    seed = 32'h0001_218e;
    resetn_in = 1'b0;
    other_reset_in = 1'b0;
    other_cause_in = '0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pins_in = '0;
    rx_data_in = 8'h00;
    conv_result_in = 8'h00;
    flag_one_set_in = 8'h00;
    flag_two_set_in = 1'b0;
    pc_step_in = 1'b0;
    repeat (12) @(posedge sys_clk_in);
    wide = {rnd(), rnd()};
    resetn_in <= 1'b1;
    pins_in <= wide[32:0];
    rx_data_in <= wide[47:40];
    conv_result_in <= wide[55:48];
    @(posedge sys_clk_in);
    for (int o = 0; o < 32; o++)
      if (!(o inside {[5:9], 26, 30})) rdchk($sformatf("reset %0h", o), ad(0, o), (o == 3) ? 32'h0000_0018 : 0);
    rdchk("cause reset", 12'h238, 32'h0000_0000);
    for (int o = 5; o < 10; o++) begin
      apb(1'b0, ad(0, o), 8'h00);
      chk("port", rd, pin_val(o));
      chk("lite port", rd_lite, (o > 7) ? 32'h0000_0000 : pin_val(o));
    end
    for (int o = 1; o < 32; o++) begin
      if (o inside {2, [5:9]}) continue;
      d = 8'(rnd());
      if (o == 3) d[7:6] = 2'b00;
      if (o == 12) d[7] = 1'b0;
      wb = (o inside {3, 4, 10, 11}) ? rnd() & 3 : 0;
      apb(1'b1, ad(wb, o), d);
      if (o == 26 || o == 30) exp = (o == 26) ? rx_data_in : conv_result_in;
      else if (o == 3) exp = (d & 8'he7) | 8'h18;
      else exp = d & mask_of(o);
      rdchk($sformatf("rw %0h", o), ad((o inside {3, 4, 10, 11}) ? rnd() & 3 : 0, o), exp);
    end
    apb(1'b1, ad(0, 1), 8'h5a);
    apb(1'b1, 12'h005, 8'hff);
    apb(1'b1, 12'h804, 8'hff);
    apb(1'b1, ad(2, 1), 8'hff);
    rdchk("misaligned", 12'h005, 0);
    rdchk("high addr", 12'h804, 0);
    rdchk("bank2 hole", ad(2, 1), 0);
    rdchk("timer0 kept", ad(0, 1), 32'h0000_005a);
    chk("image timer0", {24'h00_0000, image[1]}, 32'h0000_005a);
    apb(1'b1, ad(0, 3), 8'h00);
    apb(1'b1, ad(0, 4), 8'h25);
    d = 8'(rnd());
    apb(1'b1, ad(0, 0), d);
    rdchk("ind ram", ad(0, 8'h25), {24'h00_0000, d});
    rdchk("ind mirror", ad(2, 0), {24'h00_0000, d});
    apb(1'b1, ad(3, 4), 8'h01);
    apb(1'b1, ad(1, 0), 8'h3c);
    rdchk("ind timer0", ad(0, 1), 32'h0000_003c);
    apb(1'b1, ad(0, 4), 8'h00);
    rdchk("ind self", ad(0, 0), 0);
    apb(1'b1, ad(0, 4), 8'h03);
    rdchk("ind status", ad(0, 0), 32'h0000_0018);
    apb(1'b1, ad(0, 10), 8'hf5);
    apb(1'b1, ad(0, 2), 8'h34);
    chk("pc load", pc_out, 32'h0000_1534);
    rdchk("pc low", ad(3, 2), 32'h0000_0034);
    pc_step_in <= 1'b1;
    @(posedge sys_clk_in);
    pc_step_in <= 1'b0;
    @(negedge sys_clk_in);
    chk("pc step", pc_out, 32'h0000_1535);
    @(posedge sys_clk_in);
    apb(1'b1, ad(0, 12), 8'h00);
    d = 8'(rnd());
    flag_one_set_in <= d;
    flag_two_set_in <= 1'b1;
    @(posedge sys_clk_in);
    flag_one_set_in <= 8'h00;
    flag_two_set_in <= 1'b0;
    rdchk("flags one", ad(0, 12), {24'h00_0000, d});
    rdchk("flags two", ad(0, 13), 32'h0000_0001);
    flag_one_set_in <= 8'h01;
    apb(1'b1, ad(0, 12), 8'h00);
    flag_one_set_in <= 8'h00;
    rdchk("flag set wins", ad(0, 12), 32'h0000_0001);
    apb(1'b1, 12'h238, 8'hff);
    apb(1'b0, 12'h238, 8'h00);
    chk("cause", rd, 32'h0000_0003);
    chk("lite cause", rd_lite, 32'h0000_0002);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, ad(0, 3), 8'h27);
      apb(1'b1, ad(0, 1), 8'ha5);
      apb(1'b1, ad(0, 11), 8'hff);
      apb(1'b1, ad(0, 18), 8'h7f);
      apb(1'b1, ad(0, 16), 8'h3f);
      other_cause_in <= c[1:0];
      other_reset_in <= 1'b1;
      @(posedge sys_clk_in);
      other_reset_in <= 1'b0;
      exp = 32'h0000_0007 | (c[1] ? 0 : 32'h0000_0010) | (c[0] ? 0 : 32'h0000_0008);
      rdchk("status other", ad(0, 3), exp);
      rdchk("timer0 other", ad(0, 1), 32'h0000_00a5);
      rdchk("interrupt_control other", ad(0, 11), 32'h0000_0001);
      rdchk("t2ctrl other", ad(0, 18), 0);
      rdchk("t1ctrl other", ad(0, 16), 32'h0000_003f);
      rdchk("holding other", ad(0, 10), 0);
      rdchk("cause other", 12'h238, 32'h0000_0003);
      chk("pc other", pc_out, 0);
    end
    end_of_test();
  end
endmodule
